// ### rtl/ssr_cfg.svh
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH
`define SSR_DATA_W 48
`define SSR_ADDR_W 21
`define SSR_BYTES 6
`define SSR_BYTE_W 8
`define SSR_LOW_W 2
`define SSR_CNT_W 16
`define SSR_HK_W 8
`define SSR_MASK_NONE 6'h3F
`define SSR_CLK_PERIOD_NS 4
`define SSR_RESET_LOW_WIDTH_NS 1000
`define SSR_RESET_COMPLETION_NS 50000
`define SSR_CLOCK_SYNC_NS 20000
`define SSR_HK_BUSY_LIMIT 64
`define SSR_CYC_UP(ns) (((ns) + `SSR_CLK_PERIOD_NS - 1) / `SSR_CLK_PERIOD_NS)
`define SSR_RESET_LOW_CYCLES `SSR_CYC_UP(`SSR_RESET_LOW_WIDTH_NS)
`define SSR_RESET_COMPLETION_CYCLES `SSR_CYC_UP(`SSR_RESET_COMPLETION_NS)
`define SSR_CLOCK_SYNC_CYCLES `SSR_CYC_UP(`SSR_CLOCK_SYNC_NS)
`endif

// ### rtl/ssr_pkg.sv
package ssr_pkg;
`include "ssr_cfg.svh"
    typedef logic [`SSR_DATA_W-1:0] ssr_data_t;
    typedef logic [`SSR_ADDR_W-1:0] ssr_addr_t;
    typedef logic [`SSR_BYTES-1:0] ssr_mask_t;
    typedef enum logic [2:0] {
        OP_IDLE = 3'h1,
        OP_READ = 3'h2,
        OP_WRITE = 3'h4
    } ssr_op_e;
    typedef enum logic [4:0] {
        INIT_NEED = 5'h01,
        INIT_HOLD = 5'h02,
        INIT_RECOVER = 5'h04,
        INIT_SYNC = 5'h08,
        INIT_READY = 5'h10
    } ssr_init_e;
    typedef enum logic [2:0] {
        HOST_RESET = 3'h1,
        HOST_WAIT = 3'h2,
        HOST_RUN = 3'h4
    } ssr_host_e;
endpackage: ssr_pkg

// ### rtl/ssr_if.sv
`timescale 1ns/100ps
`include "ssr_cfg.svh"
interface ssr_if;
    import ssr_pkg::*;
    logic clock_gate_n;
    logic select_a_n;
    logic select_b;
    logic select_c_n;
    logic burst_step_or_load_n;
    logic write_n;
    ssr_mask_t byte_write_mask_n;
    logic output_enable_n;
    logic sleep_request;
    logic shutdown;
    logic reset_n;
    logic burst_order;
    ssr_addr_t addr;
    ssr_data_t dq_host_o;
    logic dq_host_oe_n;
    ssr_data_t dq_dev_o;
    logic dq_dev_oe_n;
    logic ready;
    logic idle_needed;
    wire [`SSR_DATA_W-1:0] dq;
    // The shared data wire is resolved here so the ends never touch high impedance.
    // With neither end driving, the wire settles low as the pull-downs on the pins would.
    assign dq = !dq_dev_oe_n ? dq_dev_o : (!dq_host_oe_n ? dq_host_o : '0);
    modport device(
        input clock_gate_n, select_a_n, select_b, select_c_n, burst_step_or_load_n,
        input write_n, byte_write_mask_n, output_enable_n, sleep_request, shutdown,
        input reset_n, burst_order, addr, dq,
        output dq_dev_o, dq_dev_oe_n, ready, idle_needed
    );
    modport host(
        output clock_gate_n, select_a_n, select_b, select_c_n, burst_step_or_load_n,
        output write_n, byte_write_mask_n, output_enable_n, sleep_request, shutdown,
        output reset_n, burst_order, addr, dq_host_o, dq_host_oe_n,
        input dq, ready, idle_needed
    );
endinterface: ssr_if

// ### rtl/ssr_burst_ctr.sv
`timescale 1ns/100ps
`include "ssr_cfg.svh"
module ssr_burst_ctr
    import ssr_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic load,
    input wire logic step,
    input wire logic interleave,
    input wire logic [`SSR_LOW_W-1:0] start,
    output logic [`SSR_LOW_W-1:0] next_low
);
    logic [`SSR_LOW_W-1:0] start_reg;
    logic [`SSR_LOW_W-1:0] cnt_reg;
    logic [`SSR_LOW_W-1:0] cnt_next;

    // Two-bit arithmetic wraps inside the four-word group on its own.
    assign cnt_next = cnt_reg + 2'h1;
    assign next_low = interleave ? (start_reg ^ cnt_next) : (start_reg + cnt_next);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            start_reg <= 2'h0;
            cnt_reg <= 2'h0;
        end else if (load) begin
            start_reg <= start;
            cnt_reg <= 2'h0;
        end else if (step) begin
            cnt_reg <= cnt_next;
        end
    end
endmodule: ssr_burst_ctr

// ### rtl/ssr_device.sv
// Notes on behaviour
// - Controller resets after power-up, shutdown, supply fault; the host has no supply-fault input and resets only on nrst and shutdown_req.
// - Controller holds reset low at least 1us.
// - Internal reset completes 50us after release.
// - Then 20us more to lock to clock.
// - Ready rises on the edge after that.
// - Controller waits for ready before accesses.
// - Clock rate changes only during sleep.
// - Selected only when all three selects active.
// - Load with write high starts read burst.
// - Advance continues burst, ignoring selects, write.
// - Burst write stores only bytes enabled then.
// - All byte enables high: dummy write.
// - Read with output enable high floats pins.
// - Write cycles always float the data pins.
// - Clock gate high stalls, holding current operation.
// - Shutdown overrides everything and floats pins.
// - Output enable is asynchronous, masked in writes.
// - Comes up deselected with pins floating.
// - Pins follow current operation and output enable.
// - Burst steps low bits, linear or interleaved.
// - Write data arrives one edge after command.
// - Six byte enables cover bytes low to high.
// - Blocked housekeeping flags need for idle cycle.
`timescale 1ns/100ps
`include "ssr_cfg.svh"
module ssr_device
    import ssr_pkg::*;
#(
    parameter int RECOVER_CYCLES = `SSR_RESET_COMPLETION_CYCLES,
    parameter int SYNC_CYCLES = `SSR_CLOCK_SYNC_CYCLES
)
(
    input wire logic clock,
    input wire logic nrst,
    ssr_if.device bus
);
    ssr_init_e init_reg;
    ssr_op_e op_reg;
    logic [`SSR_CNT_W-1:0] wait_cnt_reg;
    logic [`SSR_HK_W-1:0] hk_cnt_reg;
    logic [`SSR_ADDR_W-1:`SSR_LOW_W] hi_reg;
    ssr_addr_t wr_addr_reg;
    ssr_mask_t wr_mask_reg;
    logic wr_pend_reg;
    logic drive_reg;
    logic ready_reg;
    logic idle_needed_reg;
    logic order_reg;
    logic recover_done;
    logic sync_done;
    logic selected;
    logic live;
    logic edge_on;
    logic do_load;
    logic do_adv;
    logic start_rd;
    logic start_wr;
    logic acc_rd;
    logic acc_wr;
    logic commit;
    logic [`SSR_LOW_W-1:0] next_low;
    ssr_addr_t acc_addr;

    assign recover_done = wait_cnt_reg == `SSR_CNT_W'(RECOVER_CYCLES - 1);
    assign sync_done = wait_cnt_reg == `SSR_CNT_W'(SYNC_CYCLES - 1);

    // Reset sequencing. Shutdown and a low reset pin win over every other input.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            init_reg <= INIT_NEED;
        end else if (bus.shutdown) begin
            init_reg <= INIT_NEED;
        end else if (!bus.reset_n) begin
            init_reg <= INIT_HOLD;
        end else begin
            case (init_reg)
                INIT_HOLD: begin
                    init_reg <= INIT_RECOVER;
                end
                INIT_RECOVER: begin
                    if (recover_done) begin
                        init_reg <= INIT_SYNC;
                    end
                end
                INIT_SYNC: begin
                    if (sync_done) begin
                        init_reg <= INIT_READY;
                    end
                end
                default: begin
                    init_reg <= init_reg;
                end
            endcase
        end
    end

    // One counter serves both waits; it restarts at each state change.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wait_cnt_reg <= '0;
        end else if (bus.reset_n && !bus.shutdown
                     && ((init_reg == INIT_RECOVER && !recover_done)
                         || (init_reg == INIT_SYNC && !sync_done))) begin
            wait_cnt_reg <= wait_cnt_reg + `SSR_CNT_W'(1);
        end else begin
            wait_cnt_reg <= '0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= bus.reset_n && !bus.shutdown
                         && ((init_reg == INIT_SYNC && sync_done) || init_reg == INIT_READY);
        end
    end

    // The burst order is a strap, caught while the reset pin is held low.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            order_reg <= 1'b0;
        end else if (init_reg == INIT_HOLD) begin
            order_reg <= bus.burst_order;
        end
    end

    assign selected = !bus.select_a_n && bus.select_b && !bus.select_c_n;
    assign live = init_reg == INIT_READY && !bus.sleep_request && !bus.shutdown;
    assign edge_on = live && !bus.clock_gate_n;
    assign do_load = edge_on && !bus.burst_step_or_load_n;
    assign do_adv = edge_on && bus.burst_step_or_load_n && op_reg != OP_IDLE;
    assign start_rd = do_load && selected && bus.write_n;
    assign start_wr = do_load && selected && !bus.write_n;
    assign acc_rd = start_rd || (do_adv && op_reg == OP_READ);
    assign acc_wr = start_wr || (do_adv && op_reg == OP_WRITE);
    assign acc_addr = do_load ? bus.addr : {hi_reg, next_low};
    assign commit = wr_pend_reg && !bus.clock_gate_n;

    ssr_burst_ctr u_burst (
        .clock(clock),
        .nrst(nrst),
        .load(do_load),
        .step(do_adv),
        .interleave(order_reg),
        .start(bus.addr[`SSR_LOW_W-1:0]),
        .next_low(next_low)
    );

    // The kind of access is latched at the load and kept through the burst.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            op_reg <= OP_IDLE;
        end else if (!live) begin
            op_reg <= OP_IDLE;
        end else if (do_load) begin
            op_reg <= start_rd ? OP_READ : (start_wr ? OP_WRITE : OP_IDLE);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hi_reg <= '0;
        end else if (do_load) begin
            hi_reg <= bus.addr[`SSR_ADDR_W-1:`SSR_LOW_W];
        end
    end

    // A stalled edge leaves the drive state alone, so read data stays on the pins.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            drive_reg <= 1'b0;
        end else if (!live) begin
            drive_reg <= 1'b0;
        end else if (!bus.clock_gate_n) begin
            drive_reg <= acc_rd;
        end
    end

    // Masks are taken with the command; data is taken one edge later.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_mask_reg <= `SSR_MASK_NONE;
        end else if (!live) begin
            wr_pend_reg <= 1'b0;
        end else if (!bus.clock_gate_n) begin
            wr_pend_reg <= acc_wr;
            if (acc_wr) begin
                wr_addr_reg <= acc_addr;
                wr_mask_reg <= bus.byte_write_mask_n;
            end
        end
    end

    // Each byte lane is its own array, so each lane has a single writer.
    // A read of a word whose write is still pending returns the older contents.
    for (genvar b = 0; b < `SSR_BYTES; b++) begin : g_lane
        logic [`SSR_BYTE_W-1:0] mem [0:(1 << `SSR_ADDR_W)-1];
        logic [`SSR_BYTE_W-1:0] rd_q;

        always_ff @(posedge clock) begin
            if (commit && !wr_mask_reg[b]) begin
                mem[wr_addr_reg] <= bus.dq[b*`SSR_BYTE_W +: `SSR_BYTE_W];
            end
        end

        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                rd_q <= '0;
            end else if (acc_rd) begin
                rd_q <= mem[acc_addr];
            end
        end

        assign bus.dq_dev_o[b*`SSR_BYTE_W +: `SSR_BYTE_W] = rd_q;
    end

    // Output enable stays outside the clock on purpose, so it gates the driver directly.
    assign bus.dq_dev_oe_n = !(drive_reg && !bus.output_enable_n);

    // Housekeeping needs a free cycle; a long run of accesses blocks it.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hk_cnt_reg <= '0;
            idle_needed_reg <= 1'b0;
        end else if (!live) begin
            hk_cnt_reg <= '0;
            idle_needed_reg <= 1'b0;
        end else if (!bus.clock_gate_n) begin
            if (acc_rd || acc_wr) begin
                if (hk_cnt_reg == `SSR_HK_W'(`SSR_HK_BUSY_LIMIT - 1)) begin
                    idle_needed_reg <= 1'b1;
                end else begin
                    hk_cnt_reg <= hk_cnt_reg + `SSR_HK_W'(1);
                end
            end else begin
                hk_cnt_reg <= '0;
                idle_needed_reg <= 1'b0;
            end
        end
    end

    assign bus.ready = ready_reg;
    assign bus.idle_needed = idle_needed_reg;
endmodule: ssr_device

// ### rtl/ssr_host.sv
`timescale 1ns/100ps
`include "ssr_cfg.svh"
module ssr_host
    import ssr_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    ssr_if.host bus,
    input wire logic interleave_mode,
    input wire logic sleep_req,
    input wire logic shutdown_req,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_continue,
    input wire ssr_addr_t cmd_addr,
    input wire ssr_data_t cmd_wdata,
    input wire ssr_mask_t cmd_mask_n,
    output logic cmd_ready,
    output logic link_up,
    output logic rsp_valid,
    output ssr_data_t rsp_data
);
    ssr_host_e state_reg;
    logic [`SSR_CNT_W-1:0] low_cnt_reg;
    logic low_done;
    logic take;
    logic wr_stage_reg;
    logic rd_stage1_reg;
    logic rd_stage2_reg;
    ssr_data_t wdata_reg;

    assign low_done = low_cnt_reg == `SSR_CNT_W'(`SSR_RESET_LOW_CYCLES - 1);
    assign take = cmd_valid && cmd_ready;

    // Reset is driven at power-up and again after every shutdown.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= HOST_RESET;
            low_cnt_reg <= '0;
        end else if (shutdown_req) begin
            state_reg <= HOST_RESET;
            low_cnt_reg <= '0;
        end else begin
            case (state_reg)
                HOST_RESET: begin
                    low_cnt_reg <= low_cnt_reg + `SSR_CNT_W'(1);
                    if (low_done) begin
                        state_reg <= HOST_WAIT;
                    end
                end
                HOST_WAIT: begin
                    low_cnt_reg <= '0;
                    if (bus.ready) begin
                        state_reg <= HOST_RUN;
                    end
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // Commands are refused while housekeeping asks for an idle cycle.
    // Takes may follow on consecutive edges, because a deselect between beats ends a burst.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cmd_ready <= 1'b0;
            link_up <= 1'b0;
            bus.reset_n <= 1'b0;
            bus.shutdown <= 1'b0;
            bus.sleep_request <= 1'b0;
            bus.burst_order <= 1'b0;
        end else begin
            cmd_ready <= state_reg == HOST_RUN && bus.ready && !bus.idle_needed
                         && !sleep_req && !shutdown_req;
            link_up <= state_reg == HOST_RUN;
            bus.reset_n <= !(state_reg == HOST_RESET && !low_done) && !shutdown_req;
            bus.shutdown <= shutdown_req;
            bus.sleep_request <= sleep_req && !take;
            bus.burst_order <= interleave_mode;
        end
    end

    // Without a command the pins show a standby deselect.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bus.clock_gate_n <= 1'b0;
            bus.select_a_n <= 1'b1;
            bus.select_b <= 1'b0;
            bus.select_c_n <= 1'b1;
            bus.burst_step_or_load_n <= 1'b0;
            bus.write_n <= 1'b1;
            bus.byte_write_mask_n <= `SSR_MASK_NONE;
            bus.addr <= '0;
            wdata_reg <= '0;
        end else begin
            bus.select_a_n <= !take;
            bus.select_b <= take;
            bus.select_c_n <= !take;
            bus.burst_step_or_load_n <= take && cmd_continue;
            bus.write_n <= !(take && cmd_write);
            bus.byte_write_mask_n <= take ? cmd_mask_n : `SSR_MASK_NONE;
            if (take) begin
                bus.addr <= cmd_addr;
                wdata_reg <= cmd_wdata;
            end
        end
    end

    // Write data goes out one edge after the command; reads come back two edges later.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_stage_reg <= 1'b0;
            rd_stage1_reg <= 1'b0;
            rd_stage2_reg <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
            bus.dq_host_o <= '0;
            bus.dq_host_oe_n <= 1'b1;
            bus.output_enable_n <= 1'b1;
        end else begin
            wr_stage_reg <= take && cmd_write;
            rd_stage1_reg <= take && !cmd_write;
            rd_stage2_reg <= rd_stage1_reg;
            rsp_valid <= rd_stage2_reg;
            if (rd_stage2_reg) begin
                rsp_data <= bus.dq;
            end
            bus.dq_host_o <= wdata_reg;
            bus.dq_host_oe_n <= !wr_stage_reg;
            bus.output_enable_n <= wr_stage_reg;
        end
    end
endmodule: ssr_host

// ### tb/ssr_monitor.sv
`timescale 1ns/100ps
`include "ssr_cfg.svh"
module ssr_monitor
    import ssr_pkg::*;
#(
    parameter int RECOVER_CYCLES = `SSR_RESET_COMPLETION_CYCLES,
    parameter int SYNC_CYCLES = `SSR_CLOCK_SYNC_CYCLES
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clock_gate_n,
    input wire logic select_a_n,
    input wire logic select_b,
    input wire logic select_c_n,
    input wire logic burst_step_or_load_n,
    input wire logic write_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic shutdown,
    input wire logic reset_n,
    input wire logic dq_dev_oe_n,
    input wire logic ready
);
    localparam int RDY_MIN = RECOVER_CYCLES + SYNC_CYCLES - 2;
    localparam int RDY_MAX = RECOVER_CYCLES + SYNC_CYCLES + 4;
    logic [15:0] hi_cnt;
    logic live;
    logic sel;
    // Counts edges since the device reset pin was last released.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hi_cnt <= 16'h0000;
        end else if (!reset_n || shutdown) begin
            hi_cnt <= 16'h0000;
        end else if (hi_cnt != 16'hFFFF) begin
            hi_cnt <= hi_cnt + 16'h0001;
        end
    end
    assign live = ready && !clock_gate_n && !sleep_request && !shutdown;
    assign sel = !select_a_n && select_b && !select_c_n;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    a_ready_not_early: assert property (
        ready && reset_n && !shutdown && $past(reset_n) && !$past(shutdown)
        |-> hi_cnt >= RDY_MIN) else $error("ready raised too early");
    a_ready_not_late: assert property ($rose(ready) |-> hi_cnt <= RDY_MAX)
        else $error("ready raised too late");
    a_reset_drops_ready: assert property ((!reset_n || shutdown) |=> !ready)
        else $error("ready kept through reset");
    a_oe_gates_drive: assert property (output_enable_n |-> dq_dev_oe_n)
        else $error("data driven with output enable high");
    a_powerup_float: assert property (!ready && !$past(ready) |-> dq_dev_oe_n)
        else $error("data driven while not ready");
    a_write_floats: assert property (
        live && !burst_step_or_load_n && sel && !write_n |=> dq_dev_oe_n)
        else $error("data driven in write cycle");
    a_read_drives: assert property (
        live && !burst_step_or_load_n && sel && write_n |=> dq_dev_oe_n == output_enable_n)
        else $error("read drive does not follow output enable");
    a_deselect_floats: assert property (
        live && !burst_step_or_load_n && !sel |=> dq_dev_oe_n)
        else $error("data driven while deselected");
    a_shutdown_floats: assert property (shutdown |=> dq_dev_oe_n)
        else $error("data driven in shutdown");
endmodule: ssr_monitor

// ### tb/sync_sram_cmd_decode_reset_tb.sv
`timescale 1ns/100ps
module sync_sram_cmd_decode_reset_tb;
    import ssr_pkg::*;
    localparam int RECOVER = 20;
    localparam int SYNC = 10;
    localparam int HOST_LOW = 250;
    logic clock, nrst, interleave_mode, sleep_req, shutdown_req;
    logic cmd_valid, cmd_write, cmd_continue, cmd_ready, link_up, rsp_valid;
    ssr_addr_t cmd_addr;
    ssr_data_t cmd_wdata, rsp_data;
    ssr_mask_t cmd_mask_n;
    int bad_count, tests_run;
    ssr_if ssr_if_i();
    ssr_device #(.RECOVER_CYCLES(RECOVER), .SYNC_CYCLES(SYNC)) ssr_device_i(
        .clock(clock), .nrst(nrst), .bus(ssr_if_i.device));
    ssr_host ssr_host_i(.clock(clock), .nrst(nrst), .bus(ssr_if_i.host),
        .interleave_mode(interleave_mode), .sleep_req(sleep_req),
        .shutdown_req(shutdown_req), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_continue(cmd_continue), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_mask_n(cmd_mask_n), .cmd_ready(cmd_ready), .link_up(link_up),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    ssr_monitor #(.RECOVER_CYCLES(RECOVER), .SYNC_CYCLES(SYNC)) ssr_monitor_i(
        .clock(clock), .nrst(nrst), .clock_gate_n(ssr_if_i.clock_gate_n),
        .select_a_n(ssr_if_i.select_a_n), .select_b(ssr_if_i.select_b),
        .select_c_n(ssr_if_i.select_c_n), .write_n(ssr_if_i.write_n),
        .burst_step_or_load_n(ssr_if_i.burst_step_or_load_n),
        .output_enable_n(ssr_if_i.output_enable_n), .reset_n(ssr_if_i.reset_n),
        .sleep_request(ssr_if_i.sleep_request), .shutdown(ssr_if_i.shutdown),
        .dq_dev_oe_n(ssr_if_i.dq_dev_oe_n), .ready(ssr_if_i.ready));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task final_report;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask: final_report

    task check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask: check

    function automatic ssr_data_t pat(input int k);
        return {6{8'hC0 + 8'(k)}};
    endfunction: pat

    // Waits for the link to come back, counting edges from the call.
    task wait_ready(output int n);
        n = 0;
        while (ssr_if_i.ready !== 1'b1 && n < 1000) begin
            @(posedge clock);
            n++;
            if (ssr_if_i.ready !== 1'b1) check(ssr_if_i.dq_dev_oe_n === 1'b1, "pins driven");
        end
        while ((link_up !== 1'b1 || cmd_ready !== 1'b1) && n < 1100) begin
            @(posedge clock);
            n++;
        end
    endtask: wait_ready

    // Holds the command until it is taken, then leaves one edge before returning.
    task cmd(input logic wr, input logic cont, input ssr_addr_t a, input ssr_data_t d,
             input ssr_mask_t m);
        int n;
        n = 0;
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_continue <= cont;
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_mask_n <= m;
        do begin
            @(posedge clock);
            n++;
        end while (cmd_ready !== 1'b1 && n < 50);
        check(n < 50, "command not taken");
        cmd_valid <= 1'b0;
        @(posedge clock);
    endtask: cmd

    task rd(input ssr_addr_t a, input ssr_data_t exp);
        int n;
        cmd(1'b0, 1'b0, a, 48'h000000000000, 6'h3F);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (rsp_valid !== 1'b1 && n < 10);
        check(rsp_valid === 1'b1 && rsp_data === exp, "read data wrong");
    endtask: rd

    task t_bringup;
        int n;
        wait_ready(n);
        check(n >= HOST_LOW + RECOVER + SYNC && n <= HOST_LOW + RECOVER + SYNC + 8,
              "ready timing");
        $display("Test bringup done");
    endtask: t_bringup

    task t_rw_dummy;
        cmd(1'b1, 1'b0, 21'h000010, 48'h0123456789AB, 6'h00);
        rd(21'h000010, 48'h0123456789AB);
        cmd(1'b1, 1'b0, 21'h000010, 48'h000000000000, 6'h3F);
        rd(21'h000010, 48'h0123456789AB);
        $display("Test write read dummy done");
    endtask: t_rw_dummy

    task t_mask;
        ssr_data_t exp;
        exp = 48'h111111111111;
        cmd(1'b1, 1'b0, 21'h000020, exp, 6'h00);
        for (int b = 0; b < 6; b++) begin
            cmd(1'b1, 1'b0, 21'h000020, 48'hEEEEEEEEEEEE, ~(6'h01 << b));
            exp[8*b +: 8] = 8'hEE;
            rd(21'h000020, exp);
        end
        $display("Test byte masks done");
    endtask: t_mask

    task t_sleep;
        int n;
        sleep_req <= 1'b1;
        repeat (3) @(posedge clock);
        check(cmd_ready === 1'b0 && ssr_if_i.sleep_request === 1'b1, "sleep refused");
        sleep_req <= 1'b0;
        wait_ready(n);
        rd(21'h000010, 48'h0123456789AB);
        $display("Test sleep done");
    endtask: t_sleep

    // The four beats are taken on consecutive edges; a deselect between them ends the burst.
    task t_burst(input logic il, input ssr_addr_t base);
        logic [1:0] lo;
        int n;
        n = 0;
        cmd_valid <= 1'b1;
        cmd_write <= 1'b1;
        cmd_continue <= 1'b0;
        cmd_addr <= base;
        cmd_mask_n <= 6'h00;
        for (int k = 0; k < 4; k++) begin
            cmd_wdata <= pat(k);
            do begin
                @(posedge clock);
                n++;
            end while (cmd_ready !== 1'b1 && n < 50);
            if (k < 3) cmd_continue <= 1'b1;
        end
        check(n == 4, "burst beats not back to back");
        cmd_valid <= 1'b0;
        cmd_continue <= 1'b0;
        @(posedge clock);
        for (int k = 0; k < 4; k++) begin
            lo = il ? (base[1:0] ^ 2'(k)) : (base[1:0] + 2'(k));
            rd({base[20:2], lo}, pat(k));
        end
        $display("Test burst done");
    endtask: t_burst

    task t_shutdown(input logic new_order);
        int n;
        shutdown_req <= 1'b1;
        repeat (4) @(posedge clock);
        check(ssr_if_i.ready === 1'b0 && ssr_if_i.dq_dev_oe_n === 1'b1, "shutdown");
        interleave_mode <= new_order;
        shutdown_req <= 1'b0;
        wait_ready(n);
        check(link_up === 1'b1 && ssr_if_i.ready === 1'b1, "no recovery");
        $display("Test shutdown done");
    endtask: t_shutdown

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        nrst = 1'b0;
        interleave_mode = 1'b0;
        sleep_req = 1'b0;
        shutdown_req = 1'b0;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_continue = 1'b0;
        cmd_addr = 21'h000000;
        cmd_wdata = 48'h000000000000;
        cmd_mask_n = 6'h3F;
        bad_count = 0;
        tests_run = 0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        t_bringup();
        t_rw_dummy();
        t_mask();
        t_sleep();
        t_burst(1'b0, 21'h000102);
        t_shutdown(1'b1);
        t_burst(1'b1, 21'h000201);
        final_report();
    end
endmodule: sync_sram_cmd_decode_reset_tb
